// File: src/i2cc_ctrl.sv
// Control slice: DMA request control, baud count and interrupt masks
`timescale 1ns/1ns

module i2cc_ctrl
	import i2cc_pkg::*;
(
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [`I2CC_ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_we_i,
	input  wire logic                    reg_re_i,
	output logic      [31:0]             reg_rdata_o,
	input  wire logic [31:0]             raw_flags_i,
	output logic      [31:0]             irq_masked_o,
	output logic                         irq_o,
	input  wire logic                    tx_dma_en_i,
	input  wire logic [15:0]             tx_remaining_i,
	input  wire logic [9:0]              tx_fifo_space_i,
	input  wire logic                    dma_clr_i,
	output i2cc_dma_req_t                dma_req_o,
	input  wire logic                    master_en_i,
	input  wire logic                    scl_i,
	output logic                         scl_o,
	output logic                         scl_oe_o,
	output logic                         baud_tick_o
);

	localparam i2cc_top_state_t TOP_RST = '{
		burst_len:  `I2CC_DMA_CTRL_RST,
		burst_mode: 1'b0,
		baud:       `I2CC_BAUD_RST,
		mask:       `I2CC_MASK_RST,
		rdata:      32'h0000_0000,
		dma_st:     DMA_IDLE,
		req:        '{burst: 1'b0, single: 1'b0},
		irq_masked: 32'h0000_0000,
		irq:        1'b0
	};

	i2cc_top_state_t q;
	i2cc_top_state_t d;
	logic            scl_level;
	logic [8:0]      need_bytes;
	logic            use_burst;

	// Burst length code n moves two to the n bytes
	function automatic logic [8:0] burst_bytes(input logic [2:0] code);
		burst_bytes = 9'h001 << code;
	endfunction

	function automatic logic [31:0] read_word(input logic [`I2CC_ADDR_W-1:0] addr,
	                                          input i2cc_top_state_t s,
	                                          input logic scl_lvl,
	                                          input logic scl_rel);
		read_word = 32'h0000_0000;
		case (addr)
			`I2CC_DMA_CTRL_OFS: begin
				read_word[`I2CC_BLEN_MSB:`I2CC_BLEN_LSB] = s.burst_len;
				read_word[`I2CC_BURST_BIT] = s.burst_mode;
			end
			`I2CC_BAUD_OFS: begin
				read_word[`I2CC_BAUD_MSB:0] = s.baud;
			end
			`I2CC_MASK_OFS: begin
				read_word = s.mask & `I2CC_MASK_VALID;
			end
			`I2CC_STATUS_OFS: begin
				read_word[`I2CC_ST_SCL_BIT] = scl_lvl;
				read_word[`I2CC_ST_REQ_BIT] = s.req.burst | s.req.single;
				read_word[`I2CC_ST_IRQ_BIT] = s.irq;
				read_word[`I2CC_ST_REL_BIT] = scl_rel;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	endfunction

	i2cc_sync3 u_scl_sync (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (scl_i),
		.level_o   (scl_level)
	);

	i2cc_baud_gen u_baud (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.en_i        (master_en_i),
		.baud_i      (q.baud),
		.scl_level_i (scl_level),
		.scl_o       (scl_o),
		.scl_oe_o    (scl_oe_o),
		.tick_o      (baud_tick_o)
	);

	// Burst only when it fits in what is left of the transfer
	assign use_burst = q.burst_mode &&
	                   ({7'h00, burst_bytes(q.burst_len)} <= tx_remaining_i);
	assign need_bytes = use_burst ? burst_bytes(q.burst_len) : `I2CC_SINGLE_BYTES;

	always_comb begin
		d = q;

		if (reg_we_i) begin
			case (reg_addr_i)
				`I2CC_DMA_CTRL_OFS: begin
					d.burst_len = reg_wdata_i[`I2CC_BLEN_MSB:`I2CC_BLEN_LSB];
					d.burst_mode = reg_wdata_i[`I2CC_BURST_BIT];
				end
				`I2CC_BAUD_OFS: begin
					d.baud = reg_wdata_i[`I2CC_BAUD_MSB:0];
				end
				`I2CC_MASK_OFS: begin
					d.mask = 32'h0000_0000;
					d.mask[`I2CC_TX_FIFO_EMPTY_FLAG_BIT] = reg_wdata_i[`I2CC_TX_FIFO_EMPTY_FLAG_BIT];
					d.mask[`I2CC_TXFL_BIT] = reg_wdata_i[`I2CC_TXFL_BIT];
					d.mask[`I2CC_TX_FIFO_FULL_FLAG_BIT] = reg_wdata_i[`I2CC_TX_FIFO_FULL_FLAG_BIT];
					d.mask[`I2CC_TX_OVERRUN_FLAG_BIT] = reg_wdata_i[`I2CC_TX_OVERRUN_FLAG_BIT];
					d.mask[`I2CC_RX_FIFO_EMPTY_FLAG_BIT] = reg_wdata_i[`I2CC_RX_FIFO_EMPTY_FLAG_BIT];
					d.mask[`I2CC_RXFH_BIT] = reg_wdata_i[`I2CC_RXFH_BIT];
					d.mask[`I2CC_RX_FIFO_FULL_FLAG_BIT] = reg_wdata_i[`I2CC_RX_FIFO_FULL_FLAG_BIT];
					d.mask[`I2CC_SRDREQ_BIT] = reg_wdata_i[`I2CC_SRDREQ_BIT];
					d.mask[`I2CC_SRDEMP_BIT] = reg_wdata_i[`I2CC_SRDEMP_BIT];
					d.mask[`I2CC_SWRREQ_BIT] = reg_wdata_i[`I2CC_SWRREQ_BIT];
					d.mask[`I2CC_SDONE_BIT] = reg_wdata_i[`I2CC_SDONE_BIT];
					d.mask[`I2CC_MDONE_BIT] = reg_wdata_i[`I2CC_MDONE_BIT];
					d.mask[`I2CC_ARBL_BIT] = reg_wdata_i[`I2CC_ARBL_BIT];
					d.mask[`I2CC_BUS_ERROR_FLAG_BIT] = reg_wdata_i[`I2CC_BUS_ERROR_FLAG_BIT];
				end
				default: begin
					d.mask = q.mask;
				end
			endcase
		end

		// Read data stands for exactly one cycle
		d.rdata = 32'h0000_0000;
		if (reg_re_i) begin
			d.rdata = read_word(reg_addr_i, q, scl_level, scl_oe_o);
		end

		// Mask gates raw flags; unknown positions never reach the line
		d.irq_masked = raw_flags_i & q.mask & `I2CC_MASK_VALID;
		d.irq = |(raw_flags_i & q.mask & `I2CC_MASK_VALID);

		case (q.dma_st)
			DMA_IDLE: begin
				d.req = '{burst: 1'b0, single: 1'b0};
				if (tx_dma_en_i && tx_remaining_i != 16'h0000 &&
				    {1'b0, need_bytes} <= tx_fifo_space_i) begin
					d.req.burst = use_burst;
					d.req.single = !use_burst;
					d.dma_st = DMA_REQ;
				end
			end
			DMA_REQ: begin
				if (dma_clr_i || !tx_dma_en_i) begin
					d.req = '{burst: 1'b0, single: 1'b0};
					d.dma_st = dma_clr_i ? DMA_GAP : DMA_IDLE;
				end
			end
			DMA_GAP: begin
				// One idle cycle lets length and FIFO space catch up
				d.req = '{burst: 1'b0, single: 1'b0};
				d.dma_st = DMA_IDLE;
			end
			default: begin
				d.req = '{burst: 1'b0, single: 1'b0};
				d.dma_st = DMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign irq_masked_o = q.irq_masked;
	assign irq_o = q.irq;
	assign dma_req_o = q.req;

	sequence s_issue;
		q.dma_st == DMA_IDLE && tx_dma_en_i && tx_remaining_i != 16'h0000 &&
		{1'b0, need_bytes} <= tx_fifo_space_i;
	endsequence

	sequence s_single_mode;
		!q.burst_mode;
	endsequence

	sequence s_burst_fits;
		q.burst_mode && {7'h00, burst_bytes(q.burst_len)} <= tx_remaining_i;
	endsequence

	property p_single_mode_req;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_issue and s_single_mode) |=> (dma_req_o.single && !dma_req_o.burst);
	endproperty
	a_single_mode_req: assert property (p_single_mode_req)
		else $error("single mode issued a burst request");

	property p_short_tail;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_issue ##0 (q.burst_mode && {7'h00, burst_bytes(q.burst_len)} > tx_remaining_i))
		|=> (dma_req_o.single && !dma_req_o.burst);
	endproperty
	a_short_tail: assert property (p_short_tail)
		else $error("burst issued beyond remaining length");

	property p_single_space;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(q.dma_st == DMA_IDLE && tx_dma_en_i && tx_remaining_i != 16'h0000 &&
		 !q.burst_mode && tx_fifo_space_i == 10'h000) |=> !dma_req_o.single;
	endproperty
	a_single_space: assert property (p_single_space)
		else $error("single request without room for one byte");

	property p_burst_req;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_issue and s_burst_fits) |=> (dma_req_o.burst && !dma_req_o.single);
	endproperty
	a_burst_req: assert property (p_burst_req)
		else $error("fitting burst not issued as burst");

	property p_req_until_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((dma_req_o.burst || dma_req_o.single) && dma_clr_i)
		|=> (!dma_req_o.burst && !dma_req_o.single) [*2];
	endproperty
	a_req_until_clear: assert property (p_req_until_clear)
		else $error("request not dropped for two cycles after clear");

	property p_baud_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_re_i && reg_addr_i == `I2CC_BAUD_OFS)
		|=> (reg_rdata_o[31:16] == 16'h0000 && reg_rdata_o[15:0] == $past(q.baud));
	endproperty
	a_baud_read: assert property (p_baud_read)
		else $error("baud count read back wrong");

	property p_masked_out;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		1'b1 |=> (irq_masked_o == ($past(raw_flags_i) & $past(q.mask)) &&
		          irq_o == (|irq_masked_o));
	endproperty
	a_masked_out: assert property (p_masked_out)
		else $error("masked interrupt outputs disagree with flags and mask");

	property p_mask_reserved;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_we_i && reg_addr_i == `I2CC_MASK_OFS) ##1 (reg_re_i && reg_addr_i == `I2CC_MASK_OFS)
		|=> reg_rdata_o == ($past(reg_wdata_i, 2) & `I2CC_MASK_VALID);
	endproperty
	a_mask_reserved: assert property (p_mask_reserved)
		else $error("mask register reserved bits not zero");

	property p_read_one_cycle;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!reg_re_i |=> reg_rdata_o == 32'h0000_0000;
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle)
		else $error("read data stood without a read");

endmodule

// File: src/i2cc_map.svh
// Register map, field positions and reset values of the control slice
// Notes on behaviour
// - Burst length counts only in burst mode
// - Burst longer than remaining length: singles only
// - Single mode: each request moves one byte
// - Burst mode: request moves programmed burst length
// - Burst mode may finish with single requests
// - Sixteen-bit baud count, reset 8, sets clock
// - Bit 0 gates tx FIFO empty interrupt
// - Bit 1 gates tx FIFO low interrupt
// - Bit 2 gates tx FIFO full interrupt
// - Bit 3 gates tx overrun interrupt
// - Bit 4 gates rx FIFO empty interrupt
// - Bit 5 gates rx FIFO high interrupt
// - Bit 6 gates rx FIFO full interrupt
// - Bit 16 gates slave read request interrupt
// - Bit 17 gates slave read empty interrupt
// - Bit 18 gates slave write request interrupt
// - Bit 20 gates slave done interrupt
// - Bit 19 gates master done interrupt
// - Bit 24 gates arbitration lost interrupt
// - Bit 25 gates bus error interrupt
`ifndef I2CC_MAP_SVH
`define I2CC_MAP_SVH

`define I2CC_ADDR_W          8
`define I2CC_DMA_CTRL_OFS    8'h24
`define I2CC_BAUD_OFS        8'h28
`define I2CC_MASK_OFS        8'h2C
`define I2CC_STATUS_OFS      8'h30

`define I2CC_BLEN_LSB        8
`define I2CC_BLEN_MSB        10
`define I2CC_BURST_BIT       11
`define I2CC_BAUD_MSB        15

`define I2CC_DMA_CTRL_RST    3'h0
`define I2CC_BAUD_RST        16'h0008
`define I2CC_MASK_RST        32'h0000_0000
`define I2CC_MASK_VALID      32'h031F_007F

`define I2CC_TX_FIFO_EMPTY_FLAG_BIT        0
`define I2CC_TXFL_BIT        1
`define I2CC_TX_FIFO_FULL_FLAG_BIT        2
`define I2CC_TX_OVERRUN_FLAG_BIT       3
`define I2CC_RX_FIFO_EMPTY_FLAG_BIT        4
`define I2CC_RXFH_BIT        5
`define I2CC_RX_FIFO_FULL_FLAG_BIT        6
`define I2CC_SRDREQ_BIT      16
`define I2CC_SRDEMP_BIT      17
`define I2CC_SWRREQ_BIT      18
`define I2CC_MDONE_BIT       19
`define I2CC_SDONE_BIT       20
`define I2CC_ARBL_BIT        24
`define I2CC_BUS_ERROR_FLAG_BIT        25

`define I2CC_ST_SCL_BIT      0
`define I2CC_ST_REQ_BIT      1
`define I2CC_ST_IRQ_BIT      2
`define I2CC_ST_REL_BIT      3

`define I2CC_SINGLE_BYTES    9'h001

`endif

// File: src/i2cc_pkg.sv
// Types shared by the control slice modules
`include "i2cc_map.svh"

package i2cc_pkg;

	typedef enum logic [1:0] {
		DMA_IDLE,
		DMA_REQ,
		DMA_GAP
	} i2cc_dma_st_t;

	typedef struct packed {
		logic burst;
		logic single;
	} i2cc_dma_req_t;

	typedef struct packed {
		logic [2:0]    burst_len;
		logic          burst_mode;
		logic [15:0]   baud;
		logic [31:0]   mask;
		logic [31:0]   rdata;
		i2cc_dma_st_t  dma_st;
		i2cc_dma_req_t req;
		logic [31:0]   irq_masked;
		logic          irq;
	} i2cc_top_state_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic        oe;
		logic        drv;
		logic        tick;
	} i2cc_baud_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} i2cc_sync_state_t;

endpackage

// File: src/i2cc_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns

module i2cc_sync3
	import i2cc_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      level_o
);

	i2cc_sync_state_t q;
	i2cc_sync_state_t d;

	always_comb begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// First stage feeds only the second
		if (q.s2 == q.s3) begin
			d.out = q.s3;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, out: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign level_o = q.out;

endmodule

// File: src/i2cc_baud_gen.sv
// Master serial clock generator driven by the baud count
`timescale 1ns/1ns

module i2cc_baud_gen
	import i2cc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	input  wire logic [15:0] baud_i,
	input  wire logic        scl_level_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	output logic             tick_o
);

	i2cc_baud_state_t q;
	i2cc_baud_state_t d;
	logic [15:0]      lim;

	// Zero count would stall; treat it as one cycle
	assign lim = (baud_i == 16'h0000) ? 16'h0000 : baud_i - 16'h0001;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		d.drv = 1'b0;
		if (!en_i) begin
			d.oe = 1'b1;
			d.cnt = 16'h0000;
		end else if (!q.oe) begin
			if (q.cnt >= lim) begin
				d.oe = 1'b1;
				d.cnt = 16'h0000;
			end else begin
				d.cnt = q.cnt + 16'h0001;
			end
		end else if (!scl_level_i) begin
			// A slave stretching the clock holds the high phase back
			d.cnt = 16'h0000;
		end else if (q.cnt >= lim) begin
			d.oe = 1'b0;
			d.cnt = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{cnt: 16'h0000, oe: 1'b1, drv: 1'b0, tick: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign scl_o = q.drv;
	assign scl_oe_o = q.oe;
	assign tick_o = q.tick;

	property p_low_phase_len;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(en_i && !q.oe && q.cnt < lim && $stable(baud_i)) |=> !scl_oe_o;
	endproperty
	a_low_phase_len: assert property (p_low_phase_len)
		else $error("serial clock low phase ended early");

	property p_low_phase_end;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(en_i && !q.oe && q.cnt >= lim) |=> (scl_oe_o && q.cnt == 16'h0000);
	endproperty
	a_low_phase_end: assert property (p_low_phase_end)
		else $error("serial clock low phase overran the baud count");

endmodule

// File: sim/i2cc_dma_model.sv
// Behavioural DMA controller and pulled-up serial clock line
`timescale 1ns/1ns

module i2cc_dma_model
	import i2cc_pkg::*;
(
	input  wire logic          sys_clk_i,
	input  wire logic          rst_n_i,
	input  wire i2cc_dma_req_t dma_req_i,
	input  wire logic [7:0]    burst_bytes_i,
	input  wire logic [3:0]    ack_delay_i,
	input  wire logic          scl_oe_i,
	input  wire logic          load_i,
	input  wire logic [15:0]   load_len_i,
	output logic               dma_clr_o,
	output logic [15:0]        tx_remaining_o,
	output logic               scl_o
);
	int singles;
	int bursts;
	int both_err;

	// Pull-up: a released line reads high
	assign scl_o = scl_oe_i ? 1'b1 : 1'b0;

	initial begin
		dma_clr_o      = 1'b0;
		tx_remaining_o = 16'h0000;
		singles        = 0;
		bursts         = 0;
		both_err       = 0;
		forever begin
			@(posedge sys_clk_i);
			// Length is loaded here only, so the count has one driver
			if (load_i) begin
				tx_remaining_o <= load_len_i;
			end else if (rst_n_i && (dma_req_i.burst || dma_req_i.single)) begin
				if (dma_req_i.burst && dma_req_i.single)
					both_err++;
				// Slow answers keep the request standing meanwhile
				repeat (ack_delay_i) @(posedge sys_clk_i);
				if (dma_req_i.burst) begin
					bursts++;
					tx_remaining_o <= tx_remaining_o - {8'h00, burst_bytes_i};
				end else begin
					singles++;
					tx_remaining_o <= tx_remaining_o - 16'h0001;
				end
				dma_clr_o <= 1'b1;
				@(posedge sys_clk_i);
				dma_clr_o <= 1'b0;
				@(posedge sys_clk_i);
			end
		end
	end
endmodule

// File: sim/tb_i2c_dma_baud_irq_mask.sv
// Self-checking bench for the DMA, baud and interrupt mask slice
`timescale 1ns/1ns
`include "i2cc_map.svh"

module tb_i2c_dma_baud_irq_mask
	import i2cc_pkg::*;
;
	localparam int MASK_BITS [14] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18, 19, 20, 24, 25};

	logic          sys_clk_i       = 1'b0;
	logic          rst_n_i         = 1'b0;
	logic [7:0]    addr            = 8'h00;
	logic [31:0]   wdata           = 32'h0;
	logic          we              = 1'b0;
	logic          re              = 1'b0;
	logic [31:0]   flags           = 32'h0;
	logic          dma_en          = 1'b0;
	logic          master_en       = 1'b0;
	logic [9:0]    space           = 10'h3FF;
	logic [7:0]    burst_bytes     = 8'h01;
	logic [3:0]    ack_delay       = 4'h0;
	logic          load            = 1'b0;
	logic [15:0]   load_len        = 16'h0000;
	logic          scl_drv;
	logic [31:0]   rdata;
	logic [31:0]   irq_m;
	logic          irq;
	logic          clr;
	logic [15:0]   rem;
	logic          scl_pin;
	logic          scl_oe;
	logic          tick;
	i2cc_dma_req_t req;
	int            fails           = 0;
	int            samples_checked = 0;
	int            n;

	always #2 sys_clk_i = ~sys_clk_i;

	i2cc_ctrl DUT (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
		.raw_flags_i(flags), .irq_masked_o(irq_m), .irq_o(irq),
		.tx_dma_en_i(dma_en), .tx_remaining_i(rem), .tx_fifo_space_i(space),
		.dma_clr_i(clr), .dma_req_o(req), .master_en_i(master_en), .scl_i(scl_pin),
		.scl_o(scl_drv), .scl_oe_o(scl_oe), .baud_tick_o(tick)
	);

	i2cc_dma_model u_dma (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .dma_req_i(req),
		.burst_bytes_i(burst_bytes), .ack_delay_i(ack_delay), .scl_oe_i(scl_oe),
		.load_i(load), .load_len_i(load_len),
		.dma_clr_o(clr), .tx_remaining_o(rem), .scl_o(scl_pin)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge sys_clk_i);
		we    <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge sys_clk_i);
		addr <= a;
		re   <= 1'b1;
		@(posedge sys_clk_i);
		re   <= 1'b0;
		#1;
		chk(rdata, exp, what);
	endtask

	// Counts singles and bursts needed to drain len bytes
	task automatic dma_run(input logic [31:0] ctrl, input logic [15:0] len,
		input logic [7:0] bb, input int exp_s, input int exp_b);
		int s0;
		int b0;
		int k;
		wr(`I2CC_DMA_CTRL_OFS, ctrl);
		s0 = u_dma.singles;
		b0 = u_dma.bursts;
		burst_bytes <= bb;
		load_len    <= len;
		load        <= 1'b1;
		@(posedge sys_clk_i);
		load        <= 1'b0;
		dma_en      <= 1'b1;
		@(posedge sys_clk_i);
		k = 0;
		while (rem !== 16'h0000 && k < 500) begin
			@(posedge sys_clk_i);
			k++;
		end
		chk(32'(k < 500), 32'h1, "drained in time");
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk({30'h0, req}, 32'h0, "request idle");
		chk(32'(u_dma.singles - s0), 32'(exp_s), "single count");
		chk(32'(u_dma.bursts - b0), 32'(exp_b), "burst count");
		chk(32'(u_dma.both_err), 32'h0, "both request kinds");
		@(posedge sys_clk_i);
		dma_en <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run is a few hundred cycles; this is far beyond it
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd_chk(`I2CC_DMA_CTRL_OFS, 32'h0, "dma ctrl reset");
		rd_chk(`I2CC_BAUD_OFS, 32'h0000_0008, "baud reset");
		rd_chk(`I2CC_MASK_OFS, 32'h0, "mask reset");
		chk({31'h0, scl_oe}, 32'h1, "line released");
		chk({31'h0, scl_drv}, 32'h0, "line drive value");
		rd_chk(`I2CC_STATUS_OFS, 32'h0000_0009, "status idle");
		wr(`I2CC_DMA_CTRL_OFS, 32'hFFFF_FFFF);
		wr(`I2CC_BAUD_OFS, 32'hFFFF_FFFF);
		wr(`I2CC_MASK_OFS, 32'hFFFF_FFFF);
		wr(8'h40, 32'hFFFF_FFFF);
		rd_chk(`I2CC_DMA_CTRL_OFS, 32'h0000_0F00, "dma ctrl reserved");
		rd_chk(`I2CC_BAUD_OFS, 32'h0000_FFFF, "baud reserved");
		rd_chk(`I2CC_MASK_OFS, 32'h031F_007F, "mask reserved");
		rd_chk(8'h40, 32'h0, "unmapped");
		@(posedge sys_clk_i);
		flags <= 32'hFFFF_FFFF;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(irq_m, 32'h031F_007F, "all flags");
		for (int i = 0; i < 14; i++) begin
			wr(`I2CC_MASK_OFS, ~(32'h1 << MASK_BITS[i]));
			flags <= 32'h1 << MASK_BITS[i];
			repeat (3) @(posedge sys_clk_i);
			#1;
			chk({irq_m[31:1], irq}, 32'h0, "flag suppressed");
			wr(`I2CC_MASK_OFS, 32'h1 << MASK_BITS[i]);
			repeat (3) @(posedge sys_clk_i);
			#1;
			chk(irq_m, 32'h1 << MASK_BITS[i], "flag enabled");
			chk({31'h0, irq}, 32'h1, "combined line");
		end
		dma_run(32'h0000_0200, 16'h0003, 8'h04, 3, 0);
		dma_run(32'h0000_0A00, 16'h0006, 8'h04, 2, 1);
		ack_delay <= 4'h3;
		dma_run(32'h0000_0B00, 16'h0008, 8'h08, 0, 1);
		dma_run(32'h0000_0F00, 16'h0005, 8'h80, 5, 0);
		space    <= 10'h000;
		load_len <= 16'h0002;
		load     <= 1'b1;
		dma_en   <= 1'b1;
		@(posedge sys_clk_i);
		load     <= 1'b0;
		repeat (9) @(posedge sys_clk_i);
		#1;
		chk({30'h0, req}, 32'h0, "no room, no request");
		@(posedge sys_clk_i);
		space <= 10'h3FF;
		repeat (40) @(posedge sys_clk_i);
		#1;
		chk({16'h0, rem}, 32'h0, "drained once room");
		@(posedge sys_clk_i);
		dma_en <= 1'b0;
		wr(`I2CC_BAUD_OFS, 32'h0000_0003);
		master_en <= 1'b1;
		n = 0;
		while (tick !== 1'b1 && n < 200) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		n = 0;
		while (scl_oe === 1'b0 && n < 50) begin
			n++;
			@(posedge sys_clk_i);
			#1;
		end
		chk(32'(n), 32'h3, "low phase length");
		report_and_stop();
	end
endmodule
